// [pkg/dbc_pkg.sv]
// Constants, types and register map of the board control register bank
// Contract
// - Status bit 5 shows read sequencer interrupt, bit 4 write sequencer interrupt.
// - Status bit 3 shows read FIFO empty, bit 2 write FIFO full.
// - Status bits 1 and 0 enable read and write sequencers.
// - Memory control bit 1 enables bank one, bit 0 bank zero.
// - Disabled bank powers down and frees its space for expansion memory.
// - Oscillator register always reads constant 0x32, read-only.
// - Write 1 requests a semaphore; readback 1 means ownership granted.
// - Refused semaphore requests are not queued; software must retry.
// - Writing 0 releases a semaphore held by the writer.
// - At most one of host and processor owns a semaphore.
// - Reset leaves every semaphore unowned on both sides.
// - A second independent semaphore behaves the same in bit 0.
// - Line control bits 7..4 form timing mode; codes 4-15 act as 0.
// - Mode picks sync output low or half clock, and frame source.
// - Default routing: streams 0..3 to processor, daughter, transceiver, voice.
// - Line control bit 3 swaps streams three and one.
// - Line control bit 2 swaps streams two and zero.
// - Bit 1 holds multiplexer in reset, bit 0 holds transceiver.
// - Timing mode bits clear to zero at reset.
// - Interrupt register bits 7 and 6 show latched interrupts.
// - Interrupt register bits 5 and 4 show raw interrupt levels.
// - Clear/mask bits 1 and 0: 1 clears and masks, 0 enables.
// - Enabled read sequencer interrupts while FIFO not empty, waits for read.
// - Enabled write sequencer interrupts while write FIFO not full.
package dbc_pkg;
	localparam logic [31:0] ADDR_FIFO_STATUS = 32'h01380018;
	localparam logic [31:0] ADDR_MEMORY_BANK = 32'h0138001c;
	localparam logic [31:0] ADDR_OSCILLATOR = 32'h01380020;
	localparam logic [31:0] ADDR_SEMAPHORE0 = 32'h01380024;
	localparam logic [31:0] ADDR_SEMAPHORE1 = 32'h01380028;
	localparam logic [31:0] ADDR_LINE_CONTROL = 32'h0138002c;
	localparam logic [31:0] ADDR_INTERRUPT = 32'h01380030;
	localparam logic [7:0] OSCILLATOR_VALUE = 8'h32;
	localparam logic [1:0] RESET_FIFO_ENABLE = 2'h0;
	localparam logic [1:0] RESET_BANK_ENABLE = 2'h3;
	localparam logic [7:0] RESET_LINE_CONTROL = 8'h00;
	localparam logic [1:0] RESET_INT_MASK = 2'h3;
	localparam int SEQ_WRITE = 0;
	localparam int SEQ_READ = 1;
	localparam int IRQ_TRANSCEIVER = 0;
	localparam int IRQ_DAUGHTER = 1;
	localparam int FIFO_FLAG_LSB = 2;
	localparam int FIFO_IRQ_LSB = 4;
	localparam int MODE_LSB = 4;
	localparam int SWAP_TWO_ZERO_BIT = 2;
	localparam int SWAP_THREE_ONE_BIT = 3;
	localparam int MUX_RESET_BIT = 1;
	localparam int XCVR_RESET_BIT = 0;
	localparam int RAW_IRQ_LSB = 4;
	localparam int LATCH_IRQ_LSB = 6;
	localparam int SYNC_STAGES = 2;
	localparam int PIN_COUNT = 9;
	typedef enum logic {SEQ_IDLE = 1'b0, SEQ_WAIT = 1'b1} dbc_seq_t;
	typedef enum logic [1:0] {SEM_FREE = 2'b00, SEM_DSP = 2'b01, SEM_HOST = 2'b10} dbc_sem_t;
endpackage

// [src/dbc_regs.sv]
// Board control register bank on the processor external memory bus
`timescale 1ns/10ps
module dbc_regs
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic [31:0] addr_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out,
	output logic rvalid_out,
	input wire logic dsp_fifo_read_in,
	input wire logic dsp_fifo_write_in,
	input wire logic read_fifo_empty_flag_in,
	input wire logic write_fifo_full_flag_in,
	input wire logic daughter_irq_in,
	input wire logic transceiver_irq_in,
	input wire logic multiplexer_half_clock_in,
	input wire logic [3:0] local_stream_in,
	input wire logic [1:0] host_sem_request_in,
	input wire logic [1:0] host_sem_release_in,
	output logic [1:0] host_sem_owned_out,
	output logic dsp_external_irq5_out,
	output logic dsp_external_irq6_out,
	output logic [1:0] bank_memory_enable_out,
	output logic [1:0] bank_powerdown_out,
	output logic [1:0] expansion_space_out,
	output logic transceiver_sync_out,
	output logic frame_source_select_out,
	output logic multiplexer_reset_out,
	output logic transceiver_reset_out,
	output logic [3:0] dest_stream_out
);
	localparam int PIN_COUNT_W = dbc_pkg::PIN_COUNT;
	logic [PIN_COUNT_W-1:0] sync1_q;
	logic [PIN_COUNT_W-1:0] sync2_q;
	logic empty_s;
	logic full_s;
	logic [1:0] raw_s;
	logic half_clk_s;
	logic [3:0] stream_s;
	logic [1:0] fifo_en_q;
	logic [1:0] bank_en_q;
	logic [7:0] line_q;
	logic [1:0] mask_q;
	logic [1:0] latch_q;
	logic [1:0] cond;
	logic [1:0] ack;
	logic [1:0] seq_irq_q;
	logic [1:0] dsp_req;
	logic [1:0] dsp_rel;
	logic [1:0] dsp_owns;
	logic [7:0] rdata_d;
	logic [1:0] mode_eff;
	dbc_pkg::dbc_sem_t sem_q [2];
	default clocking dbc_cb @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);

	// Effective timing mode: unused codes fall back to mode 0
	function automatic logic [1:0] eff_mode(input logic [3:0] m);
		eff_mode = (m > 4'h3) ? 2'h0 : m[1:0];
	endfunction

	// Source stream index for each destination under the two swap bits
	function automatic logic [1:0] route_src(input logic [1:0] dest, input logic sw20, input logic sw31);
		logic [1:0] s;
		s = dest;
		if (sw20 && !dest[0])
			s = dest ^ 2'h2;
		else if (sw31 && dest[0])
			s = dest ^ 2'h2;
		route_src = s;
	endfunction

	// Every status, interrupt, half clock and stream pin is asynchronous; stage one feeds only stage two
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
		end
		else
		begin
			sync1_q <= {multiplexer_half_clock_in, transceiver_irq_in, daughter_irq_in,
				write_fifo_full_flag_in, read_fifo_empty_flag_in, local_stream_in};
			sync2_q <= sync1_q;
		end
	end

	assign stream_s = sync2_q[3:0];
	assign empty_s = sync2_q[4];
	assign full_s = sync2_q[5];
	assign raw_s = {sync2_q[6], sync2_q[7]};
	assign half_clk_s = sync2_q[8];

	// Register writes; undefined bits are simply not stored
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			fifo_en_q <= dbc_pkg::RESET_FIFO_ENABLE;
			bank_en_q <= dbc_pkg::RESET_BANK_ENABLE;
			line_q <= dbc_pkg::RESET_LINE_CONTROL;
			mask_q <= dbc_pkg::RESET_INT_MASK;
		end
		else if (wr_in)
		begin
			if (addr_in == dbc_pkg::ADDR_FIFO_STATUS)
				fifo_en_q <= wdata_in[1:0];
			else if (addr_in == dbc_pkg::ADDR_MEMORY_BANK)
				bank_en_q <= wdata_in[1:0];
			else if (addr_in == dbc_pkg::ADDR_LINE_CONTROL)
				line_q <= wdata_in;
			else if (addr_in == dbc_pkg::ADDR_INTERRUPT)
				mask_q <= wdata_in[1:0];
		end
	end

	// Bank controls: disabled bank sleeps and hands its space to expansion
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			bank_memory_enable_out <= dbc_pkg::RESET_BANK_ENABLE;
			bank_powerdown_out <= ~dbc_pkg::RESET_BANK_ENABLE;
			expansion_space_out <= ~dbc_pkg::RESET_BANK_ENABLE;
		end
		else
		begin
			bank_memory_enable_out <= bank_en_q;
			bank_powerdown_out <= ~bank_en_q;
			expansion_space_out <= ~bank_en_q;
		end
	end

	// Bus-master sequencers: index 1 reads, index 0 writes
	assign cond[dbc_pkg::SEQ_READ] = !empty_s;
	assign cond[dbc_pkg::SEQ_WRITE] = !full_s;
	assign ack[dbc_pkg::SEQ_READ] = dsp_fifo_read_in;
	assign ack[dbc_pkg::SEQ_WRITE] = dsp_fifo_write_in;

	generate
		for (genvar i = 0; i < 2; i++)
		begin : g_seq
			dbc_pkg::dbc_seq_t st_q;
			dbc_pkg::dbc_seq_t st_d;
			always_comb
			begin
				st_d = st_q;
				case (st_q)
					dbc_pkg::SEQ_IDLE:
						if (fifo_en_q[i] && cond[i])
							st_d = dbc_pkg::SEQ_WAIT;
					dbc_pkg::SEQ_WAIT:
						// Drop after each access so the next request is a fresh rising edge
						if (!fifo_en_q[i] || ack[i])
							st_d = dbc_pkg::SEQ_IDLE;
					default:
						st_d = dbc_pkg::SEQ_IDLE;
				endcase
			end
			always_ff @(posedge clk_in or negedge reset_n_in)
			begin
				if (!reset_n_in)
				begin
					st_q <= dbc_pkg::SEQ_IDLE;
					seq_irq_q[i] <= 1'b0;
				end
				else
				begin
					st_q <= st_d;
					seq_irq_q[i] <= (st_d == dbc_pkg::SEQ_WAIT);
				end
			end
		end
	endgenerate

	assign dsp_external_irq5_out = seq_irq_q[dbc_pkg::SEQ_READ];
	assign dsp_external_irq6_out = seq_irq_q[dbc_pkg::SEQ_WRITE];

	// Semaphores: processor wins a same-cycle tie; refused requests vanish
	assign dsp_req[0] = wr_in && addr_in == dbc_pkg::ADDR_SEMAPHORE0 && wdata_in[0];
	assign dsp_rel[0] = wr_in && addr_in == dbc_pkg::ADDR_SEMAPHORE0 && !wdata_in[0];
	assign dsp_req[1] = wr_in && addr_in == dbc_pkg::ADDR_SEMAPHORE1 && wdata_in[0];
	assign dsp_rel[1] = wr_in && addr_in == dbc_pkg::ADDR_SEMAPHORE1 && !wdata_in[0];

	generate
		for (genvar k = 0; k < 2; k++)
		begin : g_sem
			always_ff @(posedge clk_in or negedge reset_n_in)
			begin
				if (!reset_n_in)
				begin
					sem_q[k] <= dbc_pkg::SEM_FREE;
					host_sem_owned_out[k] <= 1'b0;
				end
				else
				begin
					case (sem_q[k])
						dbc_pkg::SEM_FREE:
						begin
							if (dsp_req[k])
							begin
								sem_q[k] <= dbc_pkg::SEM_DSP;
								host_sem_owned_out[k] <= 1'b0;
							end
							else if (host_sem_request_in[k])
							begin
								sem_q[k] <= dbc_pkg::SEM_HOST;
								host_sem_owned_out[k] <= 1'b1;
							end
						end
						dbc_pkg::SEM_DSP:
							if (dsp_rel[k])
								sem_q[k] <= dbc_pkg::SEM_FREE;
						dbc_pkg::SEM_HOST:
						begin
							if (host_sem_release_in[k])
							begin
								sem_q[k] <= dbc_pkg::SEM_FREE;
								host_sem_owned_out[k] <= 1'b0;
							end
						end
						default:
						begin
							sem_q[k] <= dbc_pkg::SEM_FREE;
							host_sem_owned_out[k] <= 1'b0;
						end
					endcase
				end
			end
			assign dsp_owns[k] = (sem_q[k] == dbc_pkg::SEM_DSP);
		end
	endgenerate

	// Interrupt latches; a held mask bit keeps the latch clear
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			latch_q <= 2'h0;
		else
			latch_q <= ~mask_q & (latch_q | raw_s);
	end

	// Line interface outputs
	assign mode_eff = eff_mode(line_q[dbc_pkg::MODE_LSB +: 4]);

	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			transceiver_sync_out <= 1'b0;
			frame_source_select_out <= 1'b1;
			multiplexer_reset_out <= dbc_pkg::RESET_LINE_CONTROL[dbc_pkg::MUX_RESET_BIT];
			transceiver_reset_out <= dbc_pkg::RESET_LINE_CONTROL[dbc_pkg::XCVR_RESET_BIT];
		end
		else
		begin
			// Half clock arrives two stages late; fine for a frame sync reference
			transceiver_sync_out <= mode_eff[0] & half_clk_s;
			frame_source_select_out <= !mode_eff[1];
			multiplexer_reset_out <= line_q[dbc_pkg::MUX_RESET_BIT];
			transceiver_reset_out <= line_q[dbc_pkg::XCVR_RESET_BIT];
		end
	end

	generate
		for (genvar d = 0; d < 4; d++)
		begin : g_route
			always_ff @(posedge clk_in or negedge reset_n_in)
			begin
				if (!reset_n_in)
					dest_stream_out[d] <= 1'b0;
				else
					dest_stream_out[d] <= stream_s[route_src(2'(d), line_q[dbc_pkg::SWAP_TWO_ZERO_BIT],
						line_q[dbc_pkg::SWAP_THREE_ONE_BIT])];
			end
		end
	endgenerate

	// Read multiplexer; unmapped addresses read zero
	always_comb
	begin
		rdata_d = 8'h00;
		if (addr_in == dbc_pkg::ADDR_FIFO_STATUS)
			rdata_d = {2'h0, seq_irq_q[1], seq_irq_q[0], empty_s, full_s, fifo_en_q};
		else if (addr_in == dbc_pkg::ADDR_MEMORY_BANK)
			rdata_d = {6'h00, bank_en_q};
		else if (addr_in == dbc_pkg::ADDR_OSCILLATOR)
			rdata_d = dbc_pkg::OSCILLATOR_VALUE;
		else if (addr_in == dbc_pkg::ADDR_SEMAPHORE0)
			rdata_d = {7'h00, dsp_owns[0]};
		else if (addr_in == dbc_pkg::ADDR_SEMAPHORE1)
			rdata_d = {7'h00, dsp_owns[1]};
		else if (addr_in == dbc_pkg::ADDR_LINE_CONTROL)
			rdata_d = line_q;
		else if (addr_in == dbc_pkg::ADDR_INTERRUPT)
			rdata_d = {latch_q[1], latch_q[0], raw_s[1], raw_s[0], 2'h0, mask_q};
	end

	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			rdata_out <= 8'h00;
			rvalid_out <= 1'b0;
		end
		else
		begin
			rdata_out <= rd_in ? rdata_d : 8'h00;
			rvalid_out <= rd_in;
		end
	end

	sequence s_semaphore_zero_grab;
		wr_in && addr_in == dbc_pkg::ADDR_SEMAPHORE0 && wdata_in[0] && sem_q[0] == dbc_pkg::SEM_FREE;
	endsequence
	sequence s_semaphore_zero_read;
		rd_in && addr_in == dbc_pkg::ADDR_SEMAPHORE0 && !wr_in;
	endsequence

	property p_osc;
		rd_in && addr_in == dbc_pkg::ADDR_OSCILLATOR |=> rdata_out == 8'h32 && rvalid_out;
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator readback wrong");
	property p_sem_grant;
		// The bus master leaves one idle cycle between a write and the following read
		s_semaphore_zero_grab ##1 !wr_in ##1 s_semaphore_zero_read |=> rdata_out[0];
	endproperty
	a_sem_grant: assert property (p_sem_grant) else $error("semaphore not granted");
	property p_sem_excl;
		!(host_sem_owned_out[0] && dsp_owns[0]) && !(host_sem_owned_out[1] && dsp_owns[1]);
	endproperty
	a_sem_excl: assert property (p_sem_excl) else $error("semaphore owned twice");
	property p_irq5_cause;
		$rose(dsp_external_irq5_out) |-> $past(fifo_en_q[1]) && $past(!empty_s);
	endproperty
	a_irq5_cause: assert property (p_irq5_cause) else $error("read interrupt without cause");
	property p_irq5_hold;
		dsp_external_irq5_out && fifo_en_q[1] && !dsp_fifo_read_in |=> dsp_external_irq5_out;
	endproperty
	a_irq5_hold: assert property (p_irq5_hold) else $error("read interrupt dropped early");
	property p_irq6_raise;
		!dsp_external_irq6_out && fifo_en_q[0] && !full_s ##1 fifo_en_q[0] |-> dsp_external_irq6_out;
	endproperty
	a_irq6_raise: assert property (p_irq6_raise) else $error("write interrupt missing");
	property p_latch_set;
		raw_s[1] && !mask_q[1] |=> latch_q[1];
	endproperty
	a_latch_set: assert property (p_latch_set) else $error("latch not set");
	property p_mask_clear;
		mask_q[0] [*2] |-> !latch_q[0];
	endproperty
	a_mask_clear: assert property (p_mask_clear) else $error("masked latch set");
	property p_sync_low;
		!mode_eff[0] |=> !transceiver_sync_out;
	endproperty
	a_sync_low: assert property (p_sync_low) else $error("sync not low");
	property p_frame;
		line_q[7:4] > 4'h3 |=> frame_source_select_out;
	endproperty
	a_frame: assert property (p_frame) else $error("unused mode not like mode 0");
endmodule

// [tb/dbc_dsp_model.sv]
// Processor bus master model that reaches the board control registers
`timescale 1ns/10ps
module dbc_dsp_model
(
	input wire logic clk_in,
	input wire logic [7:0] rdata_in,
	input wire logic rvalid_in,
	output logic [31:0] addr_out,
	output logic wr_out,
	output logic rd_out,
	output logic [7:0] wdata_out
);
	initial
	begin
		addr_out = 32'h0;
		wr_out = 1'h0;
		rd_out = 1'h0;
		wdata_out = 8'h00;
	end
	// Idle bus shows inverted values so a stale address cannot pass
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		@(posedge clk_in);
		#1;
		addr_out = a;
		wdata_out = d;
		wr_out = 1'h1;
		@(posedge clk_in);
		#1;
		wr_out = 1'h0;
		addr_out = ~a;
		wdata_out = ~d;
	endtask
	task automatic rd(input logic [31:0] a, output logic [7:0] d, output logic v);
		@(posedge clk_in);
		#1;
		addr_out = a;
		rd_out = 1'h1;
		@(posedge clk_in);
		#1;
		rd_out = 1'h0;
		addr_out = ~a;
		d = rdata_in;
		v = rvalid_in;
	endtask
	// No retry on refusal: a new request is the caller's choice
	task automatic sem_try(input logic [31:0] a, output logic [7:0] d);
		logic v;
		wr(a, 8'h01);
		rd(a, d, v);
	endtask
	task automatic sem_free(input logic [31:0] a);
		wr(a, 8'h00);
	endtask
endmodule

// [tb/tb.sv]
// Self-checking bench for the board control register bank
`timescale 1ns/10ps
module tb;
	typedef struct packed {logic [31:0] a; logic w; logic [7:0] d; logic [7:0] e;} dbc_row_t;
	localparam logic [31:0] A_FS = dbc_pkg::ADDR_FIFO_STATUS;
	localparam logic [31:0] A_MB = dbc_pkg::ADDR_MEMORY_BANK;
	localparam logic [31:0] A_OS = dbc_pkg::ADDR_OSCILLATOR;
	localparam logic [31:0] A_S0 = dbc_pkg::ADDR_SEMAPHORE0;
	localparam logic [31:0] A_S1 = dbc_pkg::ADDR_SEMAPHORE1;
	localparam logic [31:0] A_LC = dbc_pkg::ADDR_LINE_CONTROL;
	localparam logic [31:0] A_IN = dbc_pkg::ADDR_INTERRUPT;
	logic clk_in, reset_n_in, wr_in, rd_in, rvalid_out, dsp_fifo_read_in, dsp_fifo_write_in;
	logic read_fifo_empty_flag_in, write_fifo_full_flag_in, daughter_irq_in, transceiver_irq_in;
	logic multiplexer_half_clock_in, dsp_external_irq5_out, dsp_external_irq6_out, transceiver_sync_out;
	logic frame_source_select_out, multiplexer_reset_out, transceiver_reset_out;
	logic [31:0] addr_in, a;
	logic [7:0] wdata_in, rdata_out, d;
	logic [3:0] local_stream_in, dest_stream_out;
	logic [1:0] host_sem_request_in, host_sem_release_in, host_sem_owned_out;
	logic [1:0] bank_memory_enable_out, bank_powerdown_out, expansion_space_out;
	int error_cnt = 0;
	int cmp_count = 0;
	dbc_row_t rows [19] = '{'{A_FS, 1'h0, 8'h00, 8'h0c}, '{A_MB, 1'h0, 8'h00, 8'h03},
		'{A_OS, 1'h0, 8'h00, 8'h32}, '{A_S0, 1'h0, 8'h00, 8'h00}, '{A_S1, 1'h0, 8'h00, 8'h00},
		'{A_LC, 1'h0, 8'h00, 8'h00}, '{A_IN, 1'h0, 8'h00, 8'h03}, '{A_FS, 1'h1, 8'hff, 8'h0f},
		'{A_MB, 1'h1, 8'hfc, 8'h00}, '{A_MB, 1'h1, 8'hff, 8'h03}, '{A_OS, 1'h1, 8'h00, 8'h32},
		'{A_LC, 1'h1, 8'h5a, 8'h5a}, '{A_LC, 1'h1, 8'h00, 8'h00}, '{A_IN, 1'h1, 8'hfc, 8'h00},
		'{A_IN, 1'h1, 8'hff, 8'h03}, '{A_S1, 1'h1, 8'hff, 8'h01}, '{A_S1, 1'h1, 8'hfe, 8'h00},
		'{32'h01380034, 1'h1, 8'hff, 8'h00}, '{32'h01380019, 1'h1, 8'hff, 8'h00}};

	dbc_dsp_model bus (.clk_in, .rdata_in(rdata_out), .rvalid_in(rvalid_out), .addr_out(addr_in),
		.wr_out(wr_in), .rd_out(rd_in), .wdata_out(wdata_in));
	dbc_regs dut (.clk_in, .reset_n_in, .addr_in, .wr_in, .rd_in, .wdata_in, .rdata_out, .rvalid_out,
		.dsp_fifo_read_in, .dsp_fifo_write_in, .read_fifo_empty_flag_in, .write_fifo_full_flag_in,
		.daughter_irq_in, .transceiver_irq_in, .multiplexer_half_clock_in, .local_stream_in,
		.host_sem_request_in, .host_sem_release_in, .host_sem_owned_out, .dsp_external_irq5_out,
		.dsp_external_irq6_out, .bank_memory_enable_out, .bank_powerdown_out, .expansion_space_out,
		.transceiver_sync_out, .frame_source_select_out, .multiplexer_reset_out,
		.transceiver_reset_out, .dest_stream_out);

	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e)
		begin
			error_cnt++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic rdc(input logic [31:0] ra, input logic [7:0] e);
		logic [7:0] g;
		logic v;
		bus.rd(ra, g, v);
		cmp(8'(v), 8'h01);
		cmp(g, e);
	endtask
	// Pins cross two flops; six cycles covers the three-cycle path
	task automatic settle;
		repeat (6) @(posedge clk_in);
		#1;
	endtask
	task automatic hsem(input logic rel, input int k);
		@(posedge clk_in);
		#1;
		if (rel)
			host_sem_release_in[k] = 1'h1;
		else
			host_sem_request_in[k] = 1'h1;
		@(posedge clk_in);
		#1;
		host_sem_request_in = 2'h0;
		host_sem_release_in = 2'h0;
	endtask
	task automatic fpulse(input logic r);
		@(posedge clk_in);
		#1;
		{dsp_fifo_read_in, dsp_fifo_write_in} = {r, ~r};
		@(posedge clk_in);
		#1;
		{dsp_fifo_read_in, dsp_fifo_write_in} = 2'h0;
	endtask
	function automatic logic [3:0] route(input logic [3:0] p, input logic [1:0] s);
		route = {s[1] ? p[1] : p[3], s[0] ? p[0] : p[2], s[1] ? p[3] : p[1], s[0] ? p[2] : p[0]};
	endfunction
	task automatic finish_test;
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		clk_in = 1'h0;
		forever #10 clk_in = ~clk_in;
	end
	initial
	begin
		#200000;
		error_cnt++;
		finish_test;
	end
	initial
	begin
		{reset_n_in, dsp_fifo_read_in, dsp_fifo_write_in, daughter_irq_in, transceiver_irq_in} = 5'h0;
		{read_fifo_empty_flag_in, write_fifo_full_flag_in, multiplexer_half_clock_in} = 3'h6;
		{local_stream_in, host_sem_request_in, host_sem_release_in} = 8'h00;
		repeat (2) @(posedge clk_in);
		#1 reset_n_in = 1'h1;
		cmp(8'({bank_memory_enable_out, frame_source_select_out, transceiver_sync_out}), 8'h0e);
		settle;
		foreach (rows[i])
		begin
			if (rows[i].w)
				bus.wr(rows[i].a, rows[i].d);
			rdc(rows[i].a, rows[i].e);
		end
		bus.wr(A_MB, 8'h01);
		settle;
		cmp(8'(bank_memory_enable_out), 8'h01);
		cmp(8'({bank_powerdown_out, expansion_space_out}), 8'h0a);
		bus.wr(A_MB, 8'h03);
		for (int m = 0; m < 16; m++)
			for (int h = 0; h < 2; h++)
			begin
				multiplexer_half_clock_in = h[0];
				bus.wr(A_LC, {m[3:0], 4'h0});
				settle;
				cmp(8'(transceiver_sync_out), 8'(h[0] && (m == 1 || m == 3)));
				cmp(8'(frame_source_select_out), 8'(m != 2 && m != 3));
			end
		for (int s = 0; s < 4; s++)
		begin
			bus.wr(A_LC, {4'h0, s[1:0], s[1:0]});
			for (int i = 0; i < 4; i++)
			begin
				local_stream_in = 4'h1 << i;
				settle;
				cmp(8'(dest_stream_out), 8'(route(4'h1 << i, s[1:0])));
			end
			cmp(8'({multiplexer_reset_out, transceiver_reset_out}), 8'(s[1:0]));
		end
		bus.wr(A_LC, 8'h00);
		for (int k = 0; k < 2; k++)
		begin
			a = k ? A_S1 : A_S0;
			hsem(1'h0, k);
			cmp(8'(host_sem_owned_out[k]), 8'h01);
			bus.sem_try(a, d);
			cmp(d, 8'h00);
			hsem(1'h1, k);
			cmp(8'(host_sem_owned_out[k]), 8'h00);
			rdc(a, 8'h00);
			bus.sem_try(a, d);
			cmp(d, 8'h01);
			hsem(1'h0, k);
			cmp(8'(host_sem_owned_out[k]), 8'h00);
			bus.sem_free(a);
			rdc(a, 8'h00);
			hsem(1'h0, k);
			cmp(8'(host_sem_owned_out[k]), 8'h01);
			hsem(1'h1, k);
		end
		bus.wr(A_FS, 8'h03);
		read_fifo_empty_flag_in = 1'h0;
		settle;
		cmp(8'(dsp_external_irq5_out), 8'h01);
		rdc(A_FS, 8'h27);
		fpulse(1'h1);
		cmp(8'(dsp_external_irq5_out), 8'h00);
		settle;
		cmp(8'(dsp_external_irq5_out), 8'h01);
		bus.wr(A_FS, 8'h01);
		settle;
		cmp(8'(dsp_external_irq5_out), 8'h00);
		write_fifo_full_flag_in = 1'h0;
		settle;
		cmp(8'(dsp_external_irq6_out), 8'h01);
		rdc(A_FS, 8'h11);
		fpulse(1'h0);
		cmp(8'(dsp_external_irq6_out), 8'h00);
		bus.wr(A_FS, 8'h00);
		settle;
		cmp(8'(dsp_external_irq6_out), 8'h00);
		bus.wr(A_IN, 8'h00);
		daughter_irq_in = 1'h1;
		settle;
		rdc(A_IN, 8'ha0);
		daughter_irq_in = 1'h0;
		settle;
		rdc(A_IN, 8'h80);
		bus.wr(A_IN, 8'h02);
		{daughter_irq_in, transceiver_irq_in} = 2'h3;
		settle;
		rdc(A_IN, 8'h72);
		bus.wr(A_IN, 8'h03);
		rdc(A_IN, 8'h33);
		// Reset in mid-run with both semaphores held and a mode set
		bus.sem_try(A_S0, d);
		hsem(1'h0, 1);
		bus.wr(A_LC, 8'hf3);
		reset_n_in = 1'h0;
		repeat (2) @(posedge clk_in);
		#1 reset_n_in = 1'h1;
		cmp(8'(host_sem_owned_out), 8'h00);
		rdc(A_S0, 8'h00);
		rdc(A_LC, 8'h00);
		cmp(8'(frame_source_select_out), 8'h01);
		finish_test;
	end
endmodule
